//--- bench/xbi_bus_tb.sv
// Self-checking testbench for the external bus interface
module xbi_bus_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RSTC = 4;
  logic clk = 0, rst_n = 0, req = 0, srst = 0, iend = 0, slow = 0;
  logic hold_n = 1, x_rst = 1, nmi_n = 1, x_memory_request_n = 1;
  logic [23:0] x_addr = 24'h000000;
  xbi_pkg::xbi_req_s rq = '0;
  logic rdy, done, prst, npend, ntake, a_oe, d_oe, m_out, m_oe, q_out;
  logic q_oe, rd_n, rd_oe, wr_n, wr_oe, fi, fi_oe, gnt_n, rp_out, rp_oe;
  logic wt_n, m_in, q_in, rp_in;
  logic [7:0] rdata, d_out, d_in, s;
  logic [23:0] a_out, a_in;
  xbi_pkg::xbi_snoop_s snp;
  int err_total = 0, n_tests = 0, lat;
  wire logic [6:0] oes = {a_oe, d_oe, m_oe, q_oe, rd_oe, wr_oe, fi_oe};
  assign a_in = a_oe ? a_out : x_addr;
  assign m_in = m_oe ? m_out : x_memory_request_n;
  assign q_in = q_oe ? q_out : 1'b1;
  // Reset pin has a pull-up; the device only pulls it low
  assign rp_in = rp_oe ? 1'b0 : x_rst;
  always #50 clk = ~clk;

  xbi_bus #(.RST_PULSE_CYC(RSTC)) DUT (
    .i_clock(clk), .i_rst_n(rst_n), .i_req(req), .i_req_data(rq),
    .o_ready(rdy), .o_done(done), .o_rdata(rdata),
    .i_self_reset(srst), .o_pin_reset(prst), .i_instr_end(iend),
    .o_nmi_pending(npend), .o_nmi_take(ntake), .o_snoop(snp),
    .i_addr_in(a_in), .o_addr_out(a_out), .o_addr_oe(a_oe),
    .i_data_in(d_in), .o_data_out(d_out), .o_data_oe(d_oe),
    .i_memory_request_n(m_in), .o_memory_request_n(m_out),
    .o_memory_request_oe(m_oe), .i_io_request_n(q_in),
    .o_io_request_n(q_out), .o_io_request_oe(q_oe),
    .o_read_strobe_n(rd_n), .o_read_strobe_oe(rd_oe),
    .o_store_strobe_n(wr_n), .o_store_strobe_oe(wr_oe),
    .o_fetch_indicator(fi), .o_fetch_indicator_oe(fi_oe),
    .i_wait_n(wt_n), .i_bus_hold_request_n(hold_n),
    .o_bus_hold_grant_n(gnt_n), .i_reset_pin(rp_in),
    .o_reset_pin_out(rp_out), .o_reset_pin_oe(rp_oe), .i_nmi_n(nmi_n)
  );
  xbi_far F (
    .i_clock(clk), .i_addr(a_out), .i_dout(d_out), .i_doe(d_oe),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_soe(rd_oe), .i_slow(slow),
    .o_data(d_in), .o_wait_n(wt_n)
  );

  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask

  // Flags: addr wrong, both strobes, data oe, fetch, io, mem, wr, rd
  task automatic cyc(input logic w, io, f, input logic [23:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    lat = 0;
    s = 8'h00;
    while (rdy !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    rq = '{addr: a, wdata: d, is_write: w, is_io: io, is_fetch: f};
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    do begin
      lat++;
      s |= {(!m_out || !q_out) && a_out !== a, !rd_n && !wr_n, d_oe,
            fi, !q_out, !m_out, !wr_n, !rd_n};
      if (done === 1'b1) break;
      @(negedge clk);
    end while (lat < 40);
  endtask

  task automatic t_cycles();
    cyc(1, 0, 0, 24'h000012, 8'hA5);
    chk("mw lat", 3, lat);
    chk("mw flags", 8'h26, s);
    cyc(0, 0, 1, 24'h000012, 8'h00);
    chk("fetch flags", 8'h15, s);
    chk("fetch data", 8'hA5, rdata);
    cyc(1, 1, 0, 24'h000034, 8'h3C);
    chk("iow flags", 8'h2A, s);
    cyc(0, 1, 1, 24'h000034, 8'h00);
    chk("ior flags", 8'h09, s);
    chk("ior data", 8'h3C, rdata);
  endtask

  task automatic t_wait();
    slow = 1'b1;
    cyc(0, 0, 0, 24'h000012, 8'h00);
    slow = 1'b0;
    chk("wait lat", 1, lat > 4 && lat <= 12);
    chk("wait data", 8'hA5, rdata);
  endtask

  task automatic t_hold();
    logic [6:0] po;
    int k;
    po = 7'h7F;
    hold_n = 1'b0;
    x_addr = 24'h00ABCD;
    x_memory_request_n = 1'b0;
    for (k = 0; k < 20 && gnt_n !== 1'b0; k++) begin
      po = oes;
      @(negedge clk);
    end
    chk("oe pre grant", 0, po);
    chk("oe granted", 0, oes);
    repeat (3) @(negedge clk);
    chk("snoop", {24'h00ABCD, 2'b01}, snp);
    chk("ready granted", 0, {gnt_n, rdy});
    hold_n = 1'b1;
    x_memory_request_n = 1'b1;
    for (k = 0; k < 20 && gnt_n !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    chk("oe resumed", 7'h5F, oes);
  endtask

  task automatic t_pin();
    int n, p;
    n = 0;
    p = 0;
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    n += rp_oe;
    repeat (19) begin
      @(negedge clk);
      n += rp_oe;
      p |= prst;
    end
    chk("pulse len", RSTC, n);
    chk("pin seen", 1, p);
    chk("pin out", 0, rp_out);
    x_rst = 1'b0;
    repeat (8) @(negedge clk);
    chk("pin hold", 4'b1000, {prst, m_oe, q_oe, rdy});
    x_rst = 1'b1;
    repeat (8) @(negedge clk);
    chk("pin done", 1, rdy);
  endtask

  task automatic t_nmi();
    int k;
    nmi_n = 1'b0;
    for (k = 0; k < 10 && npend !== 1'b1; k++) @(negedge clk);
    chk("nmi pend", 1, npend);
    iend = 1'b1;
    @(negedge clk);
    iend = 1'b0;
    for (k = 0; k < 3 && ntake !== 1'b1; k++) @(negedge clk);
    chk("nmi take", 1, ntake);
    @(negedge clk);
    chk("nmi clear", 0, npend);
    nmi_n = 1'b1;
  endtask

  initial begin
    repeat (16) @(negedge clk);
    chk("reset oe", 8'h01, {oes, gnt_n});
    rst_n = 1'b1;
    @(negedge clk);
    t_cycles();
    t_wait();
    t_hold();
    t_pin();
    t_nmi();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule

//--- bench/xbi_far.sv
// Far-side memory model with a slow mode that stretches cycles
module xbi_far #(
  parameter int WAITC = 3
) (
  // Clock
  input wire logic i_clock,
  // Pins from the device
  input wire logic [23:0] i_addr,
  input wire logic [7:0] i_dout,
  input wire logic i_doe,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_soe,
  input wire logic i_slow,
  // Pins to the device
  output logic [7:0] o_data,
  output logic o_wait_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_r [256];
  logic [7:0] last_r = 8'h00;
  int cnt_r = 0;
  wire logic rd = i_soe && !i_rd_n;
  wire logic wr = i_soe && !i_wr_n;
  // Released bus shows the inverse of its last value, never a stale one
  always_comb begin
    if (i_doe) begin
      o_data = i_dout;
    end else if (rd) begin
      o_data = mem_r[i_addr[7:0]];
    end else begin
      o_data = ~last_r;
    end
  end
  always @(posedge i_clock) begin
    last_r <= o_data;
    if (wr) begin
      mem_r[i_addr[7:0]] <= o_data;
    end
    cnt_r <= (rd || wr) ? cnt_r + 1 : 0;
  end
  // Wait must be low ahead of the strobe because of the input sync lag
  assign o_wait_n = !(i_slow && cnt_r < WAITC);
endmodule

//--- rtl/xbi_bus.sv
// External memory and I/O bus interface with bus hold, reset pin and NMI
// Notes on behaviour
// [R1] Data lines are driven only in write cycles while this side owns the bus.
// [R2] io_request_n goes low for every cycle aimed at I/O space.
// [R3] In an I/O cycle the read or store strobe gives the direction.
// [R4] memory_request_n goes low for memory cycles, typed by the strobes.
// [R5] Neither request line is driven while reset is in effect.
// [R6] read_strobe_n is low while reading the addressed location.
// [R7] store_strobe_n is low while writing the addressed location.
// [R8] Strobes and fetch_indicator float while the bus is granted away.
// [R9] fetch_indicator marks memory reads that are instruction fetches.
// [R10] A low wait input stretches the strobe phase cycle by cycle.
// [R11] The reset pin is a reset input and an open-drain reset output.
// [R12] NMI is taken on a falling edge at the next instruction end, unmasked.
// [R13] An outside master asks for the bus by pulling bus_hold_request_n low.
// [R14] On a hold request the bus floats first, then the grant goes low.
// [R15] While granted, address and request lines are read as inputs.
// [R16] The grant stays low until the request is withdrawn, then drive resumes.
// [R17] Read and store strobes are never low in the same cycle.
`include "xbi_map.svh"

module xbi_bus #(
  parameter int RST_PULSE_CYC = `XBI_RST_PULSE_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Core request side
  input wire logic i_req,
  input wire xbi_pkg::xbi_req_s i_req_data,
  output logic o_ready,
  output logic o_done,
  output logic [7:0] o_rdata,
  // Core reset and interrupt side
  input wire logic i_self_reset,
  output logic o_pin_reset,
  input wire logic i_instr_end,
  output logic o_nmi_pending,
  output logic o_nmi_take,
  output xbi_pkg::xbi_snoop_s o_snoop,
  // Address pins
  input wire logic [23:0] i_addr_in,
  output logic [23:0] o_addr_out,
  output logic o_addr_oe,
  // Data pins
  input wire logic [7:0] i_data_in,
  output logic [7:0] o_data_out,
  output logic o_data_oe,
  // Request pins
  input wire logic i_memory_request_n,
  output logic o_memory_request_n,
  output logic o_memory_request_oe,
  input wire logic i_io_request_n,
  output logic o_io_request_n,
  output logic o_io_request_oe,
  // Strobe pins
  output logic o_read_strobe_n,
  output logic o_read_strobe_oe,
  output logic o_store_strobe_n,
  output logic o_store_strobe_oe,
  output logic o_fetch_indicator,
  output logic o_fetch_indicator_oe,
  // Control pins
  input wire logic i_wait_n,
  input wire logic i_bus_hold_request_n,
  output logic o_bus_hold_grant_n,
  input wire logic i_reset_pin,
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe,
  input wire logic i_nmi_n
);

  xbi_pkg::xbi_state_e state_r, state_nxt;
  xbi_pkg::xbi_req_s req_r;
  xbi_pkg::xbi_req_s req_cur;
  logic [`XBI_SYNC_W-1:0] sync_q;
  logic wait_s, hold_req_s, reset_s, nmi_s, memory_request_n_s, io_request_n_s;
  logic [23:0] addr_s;
  logic nmi_prev_r;
  logic accept;
  logic [`XBI_RST_CNT_W-1:0] rst_cnt_r;

  xbi_sync #(
    .W(`XBI_SYNC_W),
    .INIT({{4{1'b1}}, `XBI_IDLE_ADDR, 2'h3})
  ) u_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_d({i_wait_n, i_bus_hold_request_n, i_reset_pin, i_nmi_n,
          i_addr_in, i_memory_request_n, i_io_request_n}),
    .o_q(sync_q)
  );

  assign {wait_s, hold_req_s, reset_s, nmi_s, addr_s, memory_request_n_s, io_request_n_s} =
    sync_q;
  assign accept = i_req && o_ready;
  // Request in flight, including the one taken this cycle
  assign req_cur = accept ? i_req_data : req_r;

  function automatic logic owns(input xbi_pkg::xbi_state_e s);
    owns = (s != xbi_pkg::XBI_RELEASE) && (s != xbi_pkg::XBI_GRANT);
  endfunction

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      xbi_pkg::XBI_IDLE: begin
        if (o_pin_reset) begin
          state_nxt = xbi_pkg::XBI_IDLE;
        end else if (accept) begin
          state_nxt = xbi_pkg::XBI_SETUP;
        end else if (!hold_req_s) begin
          state_nxt = xbi_pkg::XBI_RELEASE; // R14
        end
      end
      xbi_pkg::XBI_SETUP: begin
        state_nxt = o_pin_reset ? xbi_pkg::XBI_IDLE : xbi_pkg::XBI_STROBE;
      end
      xbi_pkg::XBI_STROBE: begin
        if (o_pin_reset || wait_s) begin
          state_nxt = xbi_pkg::XBI_IDLE; // R10
        end
      end
      xbi_pkg::XBI_RELEASE: begin
        state_nxt = xbi_pkg::XBI_GRANT; // R14
      end
      xbi_pkg::XBI_GRANT: begin
        if (hold_req_s) begin
          state_nxt = xbi_pkg::XBI_IDLE; // R16
        end
      end
      default: begin
        state_nxt = xbi_pkg::XBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= xbi_pkg::XBI_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Request capture and core handshake
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      req_r <= '0;
      o_ready <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      if (accept) begin
        req_r <= i_req_data;
      end
      o_ready <= (state_nxt == xbi_pkg::XBI_IDLE) && reset_s;
      o_done <= (state_r == xbi_pkg::XBI_STROBE) && wait_s && !o_pin_reset;
      // Data settles during the strobe; taken once wait releases
      if ((state_r == xbi_pkg::XBI_STROBE) && wait_s && !req_r.is_write) begin
        o_rdata <= i_data_in;
      end
    end
  end

  // Address, data, request and strobe pins
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_addr_out <= `XBI_IDLE_ADDR;
      o_addr_oe <= 1'b0;
      o_data_out <= 8'h00;
      o_data_oe <= 1'b0;
      o_memory_request_n <= 1'b1;
      o_memory_request_oe <= 1'b0; // R5
      o_io_request_n <= 1'b1;
      o_io_request_oe <= 1'b0; // R5
      o_read_strobe_n <= 1'b1;
      o_read_strobe_oe <= 1'b0;
      o_store_strobe_n <= 1'b1;
      o_store_strobe_oe <= 1'b0;
      o_fetch_indicator <= 1'b0;
      o_fetch_indicator_oe <= 1'b0;
    end else begin
      o_addr_oe <= owns(state_nxt) && !o_pin_reset;
      o_memory_request_oe <= owns(state_nxt) && !o_pin_reset; // R5 R15
      o_io_request_oe <= owns(state_nxt) && !o_pin_reset; // R5 R15
      o_read_strobe_oe <= owns(state_nxt) && !o_pin_reset; // R8
      o_store_strobe_oe <= owns(state_nxt) && !o_pin_reset; // R8
      o_fetch_indicator_oe <= owns(state_nxt) && !o_pin_reset; // R8
      o_memory_request_n <= 1'b1;
      o_io_request_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_store_strobe_n <= 1'b1;
      o_fetch_indicator <= 1'b0;
      o_data_oe <= 1'b0;
      if ((state_nxt == xbi_pkg::XBI_SETUP) ||
          (state_nxt == xbi_pkg::XBI_STROBE)) begin
        o_memory_request_n <= req_cur.is_io; // R4
        o_io_request_n <= !req_cur.is_io; // R2
        o_fetch_indicator <= req_cur.is_fetch && !req_cur.is_io &&
                             !req_cur.is_write; // R9
      end
      if (state_nxt == xbi_pkg::XBI_SETUP) begin
        o_addr_out <= req_cur.addr;
        o_data_out <= req_cur.wdata;
      end
      if (state_nxt == xbi_pkg::XBI_STROBE) begin
        o_read_strobe_n <= req_r.is_write; // R3 R6 R17
        o_store_strobe_n <= !req_r.is_write; // R3 R7 R17
        o_data_oe <= req_r.is_write; // R1
      end
    end
  end

  // Grant follows the float by one cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_bus_hold_grant_n <= 1'b1;
      o_snoop <= '1;
    end else begin
      o_bus_hold_grant_n <= !(state_nxt == xbi_pkg::XBI_GRANT); // R14 R16
      if (state_r == xbi_pkg::XBI_GRANT) begin
        o_snoop <= {addr_s, memory_request_n_s, io_request_n_s}; // R15
      end
    end
  end

  // Open-drain reset output and reset seen on the pin
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rst_cnt_r <= '0;
      o_reset_pin_oe <= 1'b0;
      o_reset_pin_out <= 1'b0;
      o_pin_reset <= 1'b0;
    end else begin
      if (i_self_reset) begin
        rst_cnt_r <= `XBI_RST_CNT_W'(RST_PULSE_CYC);
      end else if (rst_cnt_r != '0) begin
        rst_cnt_r <= rst_cnt_r - `XBI_RST_CNT_W'(1);
      end
      o_reset_pin_oe <= i_self_reset || (rst_cnt_r > `XBI_RST_CNT_W'(1)); // R11
      o_reset_pin_out <= 1'b0;
      o_pin_reset <= !reset_s; // R11
    end
  end

  // Falling-edge NMI; a new edge beats the clear in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      nmi_prev_r <= 1'b1;
      o_nmi_pending <= 1'b0;
      o_nmi_take <= 1'b0;
    end else begin
      nmi_prev_r <= nmi_s;
      o_nmi_take <= o_nmi_pending && i_instr_end; // R12
      if (nmi_prev_r && !nmi_s) begin
        o_nmi_pending <= 1'b1; // R12
      end else if (i_instr_end) begin
        o_nmi_pending <= 1'b0;
      end
    end
  end

  default clocking bus_clk @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  a_data_write_only: assert property ( // R1
    o_data_oe |-> (state_r == xbi_pkg::XBI_STROBE) && req_r.is_write &&
                  o_bus_hold_grant_n)
    else $error("data driven outside a write");
  a_io_request_low: assert property ( // R2
    (state_r == xbi_pkg::XBI_STROBE) && req_r.is_io && o_io_request_oe
      |-> !o_io_request_n && o_memory_request_n)
    else $error("io request not low in io cycle");
  a_io_direction: assert property ( // R3
    (state_r == xbi_pkg::XBI_STROBE) && req_r.is_io && o_read_strobe_oe
      |-> (o_read_strobe_n != o_store_strobe_n))
    else $error("io cycle without direction strobe");
  a_mem_request_low: assert property ( // R4
    $rose(state_r == xbi_pkg::XBI_SETUP) && !req_r.is_io && o_addr_oe &&
      !o_pin_reset |-> !o_memory_request_n ##1 !o_memory_request_n)
    else $error("memory request not held through cycle");
  // Reset itself is the case checked here, so nothing disables it
  a_reset_float: assert property ( // R5
    disable iff (1'b0)
    (!i_rst_n || o_pin_reset) |=> !o_memory_request_oe && !o_io_request_oe)
    else $error("request line driven in reset");
  a_read_strobe: assert property ( // R6
    $rose(state_r == xbi_pkg::XBI_STROBE) && !req_r.is_write && !o_pin_reset
      |-> !o_read_strobe_n && $past(o_read_strobe_n))
    else $error("read strobe missing");
  a_write_strobe: assert property ( // R7
    $rose(state_r == xbi_pkg::XBI_STROBE) && req_r.is_write && !o_pin_reset
      |-> !o_store_strobe_n && o_data_oe)
    else $error("store strobe missing");
  a_grant_float: assert property ( // R8
    !o_bus_hold_grant_n |-> !o_read_strobe_oe && !o_store_strobe_oe &&
      !o_fetch_indicator_oe && !o_addr_oe && !o_data_oe)
    else $error("pins driven while granted");
  a_fetch_qualify: assert property ( // R9
    o_fetch_indicator |-> !o_memory_request_n && o_io_request_n &&
      o_store_strobe_n && !req_r.is_write &&
      ((state_r != xbi_pkg::XBI_STROBE) || !o_read_strobe_n))
    else $error("fetch indicator without memory read");
  a_wait_stretch: assert property ( // R10
    (state_r == xbi_pkg::XBI_STROBE) && !wait_s && !o_pin_reset
      |=> (state_r == xbi_pkg::XBI_STROBE) && !o_done)
    else $error("cycle ended during wait");
  // Two cycles is the shortest pulse the parameter may be set to
  a_reset_pulse: assert property ( // R11
    i_self_reset |=> o_reset_pin_oe [*2])
    else $error("reset pulse too short");
  a_nmi_edge: assert property ( // R12
    nmi_prev_r && !nmi_s |=> o_nmi_pending)
    else $error("nmi edge lost");
  a_hold_grant: assert property ( // R14
    (state_r == xbi_pkg::XBI_IDLE) && !hold_req_s && !accept && !o_pin_reset
      |=> !o_addr_oe && o_bus_hold_grant_n ##1 !o_bus_hold_grant_n)
    else $error("grant before float");
  a_hold_keep: assert property ( // R16
    (state_r == xbi_pkg::XBI_GRANT) && !hold_req_s
      |=> !o_bus_hold_grant_n && (state_r == xbi_pkg::XBI_GRANT))
    else $error("grant dropped while still requested");
  a_hold_resume: assert property ( // R16
    (state_r == xbi_pkg::XBI_GRANT) && hold_req_s && !o_pin_reset
      |=> o_bus_hold_grant_n && o_addr_oe)
    else $error("bus not resumed after hold");
  a_snoop_track: assert property ( // R15
    (state_r == xbi_pkg::XBI_GRANT) |=> o_snoop.addr == $past(addr_s))
    else $error("master address not captured");
  a_strobe_exclusive: assert property ( // R17
    !(!o_read_strobe_n && !o_store_strobe_n))
    else $error("both strobes low");

endmodule

//--- rtl/xbi_map.svh
// Widths, timing counts and reset values of the external bus interface
`ifndef XBI_MAP_SVH
`define XBI_MAP_SVH

`define XBI_ADDR_W 24
`define XBI_DATA_W 8
`define XBI_CLK_PERIOD_NS 100
`define XBI_RST_PULSE_NS 1600
`define XBI_RST_PULSE_CYC \
  ((`XBI_RST_PULSE_NS + `XBI_CLK_PERIOD_NS - 1) / `XBI_CLK_PERIOD_NS)
`define XBI_RST_CNT_W 8
`define XBI_IDLE_ADDR 24'h000000
`define XBI_SYNC_W 30

`endif

//--- rtl/xbi_pkg.sv
// Types shared by the external bus interface
package xbi_pkg;

  typedef enum logic [2:0] {
    XBI_IDLE    = 3'b000,
    XBI_SETUP   = 3'b001,
    XBI_STROBE  = 3'b010,
    XBI_RELEASE = 3'b011,
    XBI_GRANT   = 3'b100
  } xbi_state_e;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic is_write;
    logic is_io;
    logic is_fetch;
  } xbi_req_s;

  typedef struct packed {
    logic [23:0] addr;
    logic memory_request_n;
    logic io_request_n;
  } xbi_snoop_s;

endpackage

//--- rtl/xbi_sync.sv
// Two-flop synchroniser for the pin inputs
module xbi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      meta_r <= INIT;
      o_q <= INIT;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end

endmodule
